//--- dv/flash_descriptor_loader_bench.sv
// Purpose: self-checking bench for the descriptor loader
// Assumes: inputs change at the falling clock edge
// Notes: cases are bad signature, slow set, fast set with no init, fast set
`timescale 1ns/1ps
module flash_descriptor_loader_bench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic turbo_in = 1'b0;
  logic fatal_in = 1'b0;
  logic go = 1'b0;
  logic [15:0] req_len = 16'h0000;
  logic busy, bvalid, done, dvalid, quad, full, tinit, boot, ireq, idone, v;
  logic [7:0] bdata;
  logic [7:0] d [730];
  logic [23:0] img;
  logic [15:0] esize, wlen;
  fdl_pkg::cmd_set_t cmds, ec;
  fdl_pkg::init_req_t entry, ee;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'hC9F6;
  always #2 clk_in = ~clk_in;
  flash_descriptor_loader u_flash_descriptor_loader (
    .CLK_IN(clk_in), .RESET_IN(reset_in), .START_IN(start_in), .TURBO_MODE_IN(turbo_in),
    .FATAL_ERROR_IN(fatal_in), .WRITE_REQ_LEN_IN(req_len), .BYTE_VALID_IN(bvalid),
    .BYTE_DATA_IN(bdata), .INIT_DONE_IN(idone), .DONE_OUT(done), .DESC_VALID_OUT(dvalid),
    .QUAD_MODE_OUT(quad), .FULL_SPEED_OUT(full), .TURBO_INIT_OUT(tinit), .BOOT_OUT(boot),
    .IMAGE_ADDR_OUT(img), .ERASE_SIZE_OUT(esize), .WRITE_LEN_OUT(wlen), .CMDS_OUT(cmds),
    .INIT_REQ_OUT(ireq), .INIT_ENTRY_OUT(entry)
  );
  flash_model u_flash_model (
    .clk_in(clk_in), .go_in(go), .init_req_in(ireq), .init_entry_in(entry), .busy_out(busy),
    .byte_valid_out(bvalid), .byte_data_out(bdata), .init_done_out(idone)
  );
  task automatic chk(input string nm, input logic [559:0] e, input logic [559:0] s);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #80000;
    n_errors++;
    summarize();
  end
  initial
  begin
    int b, idx, len, sw, ws;
    logic [2:0] fl;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      for (int i = 0; i < 730; i++)
        d[i] = 8'($random(seed));
      fl = 3'(12'h8A8 >> (3 * c));
      turbo_in = c > 1;
      fatal_in = c != 3;
      req_len = 16'($random(seed) & 511);
      b = turbo_in ? 32'h51 : 32'h9;
      idx = $random(seed) & 7;
      len = c == 2 ? 0 : 1 + ($random(seed) & 7);
      sw = c == 1 ? idx + len : idx + len / 2;
      // a near-miss signature in case 0 must still be rejected
      d[0:3] = '{8'hA7, 8'hF1, 8'hA5, c == 0 ? 8'hF0 : 8'hF1};
      d[7] = d[7] | 8'h01;
      d[8] = 8'h00;
      {d[b + 64], d[b + 65], d[b + 66], d[b + 67], d[b + 68], d[b + 69]} =
        {8'(idx), 8'h00, 8'(len), 8'h00, 8'(sw), 8'h00};
      d[729][2:0] = fl;
      u_flash_model.mem = d;
      v = c != 0;
      ws = d[7];
      for (int k = 0; k < 16; k++)
        for (int j = 0; j < 4; j++)
          ec[48 + 128 * (3 - j) + 8 * k +: 8] = d[b + 16 * j + k];
      ec[47:0] = {d[b + 65], d[b + 64], d[b + 67], d[b + 66], d[b + 69], d[b + 68]};
      if (done)
      begin
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        @(negedge clk_in);
      end
      start_in = 1'b1;
      go = 1'b1;
      u_flash_model.seen.delete();
      @(negedge clk_in);
      start_in = 1'b0;
      go = 1'b0;
      for (int t = 0; t < 3000 && !(done === 1'b1 && !busy); t++)
        @(negedge clk_in);
      chk("finished", 1'b1, done === 1'b1 && !busy);
      chk("valid", v, dvalid);
      chk("commands", v ? ec : '0, cmds);
      chk("erase size", v ? {d[6], d[5]} : 16'h0000, esize);
      if (v)
        chk("write len", req_len < ws ? req_len : ws, wlen);
      chk("flags", v ? d[729][1:0] : 2'b00, {tinit, full});
      chk("boot", !(v && fl[2] && fatal_in), boot);
      chk("image", 24'h001F84, img);
      chk("quad", v && len > 0 && sw < idx + len, quad);
      chk("entries", v ? len : 0, u_flash_model.seen.size());
      foreach (u_flash_model.seen[k])
      begin
        ee.index = 5'(idx + k);
        for (int j = 0; j < 16; j++)
          {ee.cmd[8 * j +: 8], ee.payload[8 * j +: 8]} = {d[153 + 32 * (idx + k) + j],
            d[169 + 32 * (idx + k) + j]};
        chk("entry", ee, u_flash_model.seen[k]);
      end
    end
    summarize();
  end
endmodule

//--- dv/flash_descriptor_loader_props.sv
// Purpose: port checks for the descriptor loader
// Assumes: one clock domain, reset asynchronous and active high
// Notes: bound to every loader instance
`timescale 1ns/1ps
module flash_descriptor_loader_props (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // inputs watched
  input wire logic START_IN,
  input wire logic INIT_DONE_IN,
  input wire logic [15:0] WRITE_REQ_LEN_IN,
  // outputs watched
  input wire logic DONE_OUT,
  input wire logic DESC_VALID_OUT,
  input wire logic QUAD_MODE_OUT,
  input wire logic BOOT_OUT,
  input wire logic [23:0] IMAGE_ADDR_OUT,
  input wire logic [15:0] WRITE_LEN_OUT,
  input wire fdl_pkg::cmd_set_t CMDS_OUT,
  input wire logic INIT_REQ_OUT,
  input wire fdl_pkg::init_req_t INIT_ENTRY_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_img; IMAGE_ADDR_OUT == 24'h001F84; endproperty
  a_img: assert property (p_img) else $error("image start moved");
  property p_single; !DESC_VALID_OUT |-> !QUAD_MODE_OUT; endproperty
  a_single: assert property (p_single) else $error("enhanced mode without descriptor");
  property p_fallback; DONE_OUT && !DESC_VALID_OUT |-> CMDS_OUT == '0 && BOOT_OUT; endproperty
  a_fallback: assert property (p_fallback) else $error("fields used without descriptor");
  property p_wlen;
    DONE_OUT && $past(DONE_OUT) && $stable(WRITE_REQ_LEN_IN)
      && $past(WRITE_REQ_LEN_IN, 2) == WRITE_REQ_LEN_IN |-> WRITE_LEN_OUT <= WRITE_REQ_LEN_IN;
  endproperty
  a_wlen: assert property (p_wlen) else $error("write length above request");
  property p_idx; INIT_REQ_OUT |-> INIT_ENTRY_OUT.index < fdl_pkg::INIT_ENTRIES; endproperty
  a_idx: assert property (p_idx) else $error("init index past array");
  property p_hold; INIT_REQ_OUT && !INIT_DONE_IN |=> INIT_REQ_OUT && $stable(INIT_ENTRY_OUT); endproperty
  a_hold: assert property (p_hold) else $error("init entry dropped early");
  property p_switch;
    $rose(QUAD_MODE_OUT) |-> $past(INIT_DONE_IN, 2) && $past(INIT_REQ_OUT, 2)
      && $past(INIT_ENTRY_OUT.index, 2) == CMDS_OUT.switch_idx[4:0];
  endproperty
  a_switch: assert property (p_switch) else $error("switchover at wrong entry");
  property p_boot;
    DONE_OUT && !START_IN && !$past(START_IN) |=> DONE_OUT && $stable(BOOT_OUT);
  endproperty
  a_boot: assert property (p_boot) else $error("boot decision changed");
  c_valid: cover property (DONE_OUT && DESC_VALID_OUT);
  c_invalid: cover property (DONE_OUT && !DESC_VALID_OUT);
  c_quad: cover property ($rose(QUAD_MODE_OUT));
endmodule
bind flash_descriptor_loader flash_descriptor_loader_props u_props (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .START_IN(START_IN), .INIT_DONE_IN(INIT_DONE_IN),
  .WRITE_REQ_LEN_IN(WRITE_REQ_LEN_IN), .DONE_OUT(DONE_OUT), .DESC_VALID_OUT(DESC_VALID_OUT),
  .QUAD_MODE_OUT(QUAD_MODE_OUT), .BOOT_OUT(BOOT_OUT), .IMAGE_ADDR_OUT(IMAGE_ADDR_OUT),
  .WRITE_LEN_OUT(WRITE_LEN_OUT), .CMDS_OUT(CMDS_OUT), .INIT_REQ_OUT(INIT_REQ_OUT),
  .INIT_ENTRY_OUT(INIT_ENTRY_OUT)
);

//--- dv/flash_model.sv
// Purpose: flash stand-in streaming sector 0 and executing init entries
// Assumes: go_in is a one-cycle pulse
// Notes: data inverts on every idle cycle between beats
`timescale 1ns/1ps
module flash_model (
  // clock
  input wire logic clk_in,
  // requests
  input wire logic go_in,
  input wire logic init_req_in,
  input wire fdl_pkg::init_req_t init_entry_in,
  // answers
  output logic busy_out = 1'b0,
  output logic byte_valid_out = 1'b0,
  output logic [7:0] byte_data_out = 8'h00,
  output logic init_done_out = 1'b0
);
  logic [7:0] mem [730];
  fdl_pkg::init_req_t seen [$];
  int seed = 32'hC9F6;
  initial
  forever
  begin
    @(posedge clk_in);
    if (go_in)
    begin
      busy_out = 1'b1;
      for (int i = 0; i < 730; i++)
      begin
        @(negedge clk_in);
        // random gaps keep the loader honest about byte_valid
        while (($random(seed) & 3) == 0)
        begin
          byte_valid_out = 1'b0;
          byte_data_out = ~byte_data_out;
          @(negedge clk_in);
        end
        byte_valid_out = 1'b1;
        byte_data_out = mem[i];
      end
      @(negedge clk_in);
      byte_valid_out = 1'b0;
      byte_data_out = ~byte_data_out;
      busy_out = 1'b0;
    end
  end
  initial
  forever
  begin
    @(negedge clk_in);
    init_done_out = 1'b0;
    if (init_req_in)
    begin
      repeat ($random(seed) & 3) @(negedge clk_in);
      seen.push_back(init_entry_in);
      init_done_out = 1'b1;
    end
  end
endmodule

//--- logic/flash_descriptor_loader.sv
// Purpose: parse the sector-0 descriptor and steer flash access setup
// Assumes: a fetch engine streams sector-0 bytes, then obeys our requests
// Notes: only the selected command set is stored, to keep area small
`timescale 1ns/1ps
module flash_descriptor_loader (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // control
  input wire logic START_IN,
  input wire logic TURBO_MODE_IN,
  input wire logic FATAL_ERROR_IN,
  input wire logic [15:0] WRITE_REQ_LEN_IN,
  // descriptor byte stream
  input wire logic BYTE_VALID_IN,
  input wire logic [7:0] BYTE_DATA_IN,
  // init entry execution handshake
  input wire logic INIT_DONE_IN,
  // results
  output logic DONE_OUT,
  output logic DESC_VALID_OUT,
  output logic QUAD_MODE_OUT,
  output logic FULL_SPEED_OUT,
  output logic TURBO_INIT_OUT,
  output logic BOOT_OUT,
  output logic [23:0] IMAGE_ADDR_OUT,
  output logic [15:0] ERASE_SIZE_OUT,
  output logic [15:0] WRITE_LEN_OUT,
  output fdl_pkg::cmd_set_t CMDS_OUT,
  output logic INIT_REQ_OUT,
  output fdl_pkg::init_req_t INIT_ENTRY_OUT
);
  typedef struct packed {
    fdl_pkg::state_t st;
    logic [9:0] ofs;
    logic [31:0] sig;
    logic [15:0] erase_size;
    logic [15:0] write_size;
    fdl_pkg::cmd_set_t set;
    logic [7:0] flags;
    logic [15:0] run_idx;
    logic [15:0] run_left;
    logic switched;
    logic init_req;
    logic done;
    logic boot;
    logic [15:0] wr_len;
  } regs_t;

  regs_t q;
  regs_t d;
  // init array holds 18 entries of 32 bytes each
  logic [7:0] init_mem [0:575];
  logic [9:0] init_wofs;
  logic [9:0] set_base;
  logic [9:0] set_rel;
  logic [9:0] rd_base;
  logic [6:0] set_bit;
  logic [3:0] half_bit;
  logic in_set;
  logic in_init;
  logic sig_ok;
  logic [255:0] entry_bits;

  // slow mode reads the first set, fast mode the second
  assign set_base = TURBO_MODE_IN ? fdl_pkg::OFS_SET_FAST : fdl_pkg::OFS_SET_SLOW;
  assign set_rel = q.ofs - set_base;
  assign in_set = (q.ofs >= set_base) && (set_rel < fdl_pkg::SET_BYTES);
  assign in_init = (q.ofs >= fdl_pkg::OFS_INIT) && (q.ofs < fdl_pkg::OFS_FLAGS);
  assign init_wofs = q.ofs - fdl_pkg::OFS_INIT;
  assign sig_ok = (q.sig == fdl_pkg::SIGNATURE);
  // entry read follows the next index so a new request never shows the old entry
  assign rd_base = {d.run_idx[4:0], 5'h00};
  assign set_bit = {set_rel[3:0], 3'b000};
  assign half_bit = {set_rel[0], 3'b000};

  always_ff @(posedge CLK_IN)
  begin
    if (q.st == fdl_pkg::ST_LOAD && BYTE_VALID_IN && in_init)
    begin
      init_mem[init_wofs] <= BYTE_DATA_IN;
    end
  end

  // command words gathered little-endian, entry = 16 command + 16 payload bytes
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : gather
      assign entry_bits[g*8 +: 8] = init_mem[rd_base + 10'(g)];
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.init_req = 1'b0;
    case (q.st)
      fdl_pkg::ST_IDLE:
      begin
        if (START_IN)
        begin
          d.st = fdl_pkg::ST_LOAD;
          d.ofs = '0;
          d.done = 1'b0;
          d.boot = 1'b0;
          d.switched = 1'b0;
        end
      end
      fdl_pkg::ST_LOAD:
      begin
        if (BYTE_VALID_IN)
        begin
          if (q.ofs <= fdl_pkg::OFS_SIG3)
          begin
            d.sig[q.ofs[1:0]*8 +: 8] = BYTE_DATA_IN;
          end
          if (q.ofs == fdl_pkg::OFS_ERASE_LO) d.erase_size[7:0] = BYTE_DATA_IN;
          if (q.ofs == fdl_pkg::OFS_ERASE_HI) d.erase_size[15:8] = BYTE_DATA_IN;
          if (q.ofs == fdl_pkg::OFS_WRITE_LO) d.write_size[7:0] = BYTE_DATA_IN;
          if (q.ofs == fdl_pkg::OFS_WRITE_HI) d.write_size[15:8] = BYTE_DATA_IN;
          if (in_set && set_rel < 10'(fdl_pkg::SET_INIT_IDX))
          begin
            // command bytes land little-endian: byte 0 of a field fills its bits 7:0
            case (set_rel[5:4])
              fdl_pkg::SET_CHIP_ERASE[5:4]:
                d.set.chip_erase[set_bit +: 8] = BYTE_DATA_IN;
              fdl_pkg::SET_SECT_ERASE[5:4]:
                d.set.sect_erase[set_bit +: 8] = BYTE_DATA_IN;
              fdl_pkg::SET_READ[5:4]:
                d.set.read_cmd[set_bit +: 8] = BYTE_DATA_IN;
              default:
                d.set.write_cmd[set_bit +: 8] = BYTE_DATA_IN;
            endcase
          end
          // the reserved pair after the switchover index is skipped
          if (in_set && set_rel[6:1] == fdl_pkg::SET_INIT_IDX[6:1])
          begin
            d.set.init_idx[half_bit +: 8] = BYTE_DATA_IN;
          end
          if (in_set && set_rel[6:1] == fdl_pkg::SET_INIT_LEN[6:1])
          begin
            d.set.init_len[half_bit +: 8] = BYTE_DATA_IN;
          end
          if (in_set && set_rel[6:1] == fdl_pkg::SET_SWITCH[6:1])
          begin
            d.set.switch_idx[half_bit +: 8] = BYTE_DATA_IN;
          end
          if (q.ofs == fdl_pkg::OFS_FLAGS)
          begin
            d.flags = BYTE_DATA_IN;
            d.st = fdl_pkg::ST_INIT;
          end
          d.ofs = q.ofs + 10'h001;
          // signature failure ends the load early
          if (q.ofs == fdl_pkg::OFS_SIG3 + 10'h001 && !sig_ok)
          begin
            d.st = fdl_pkg::ST_BOOT;
          end
        end
      end
      fdl_pkg::ST_INIT:
      begin
        if (q.ofs == fdl_pkg::OFS_FLAGS + 10'h001)
        begin
          // first pass: load the run window from the set
          d.run_idx = q.set.init_idx;
          d.run_left = q.set.init_len;
          d.ofs = '0;
          if (q.set.init_len == 16'h0000 || q.set.init_idx >= 16'(fdl_pkg::INIT_ENTRIES))
          begin
            d.st = fdl_pkg::ST_BOOT;
          end
          else
          begin
            d.init_req = 1'b1;
          end
        end
        else if (q.init_req && INIT_DONE_IN)
        begin
          // request drops for one cycle so the executor never repeats an entry
          if (q.run_idx == q.set.switch_idx)
          begin
            d.switched = 1'b1;
          end
          d.run_idx = q.run_idx + 16'h0001;
          d.run_left = q.run_left - 16'h0001;
          if (q.run_left == 16'h0001 || q.run_idx + 16'h0001 >= 16'(fdl_pkg::INIT_ENTRIES))
          begin
            d.st = fdl_pkg::ST_BOOT;
          end
        end
        else
        begin
          d.init_req = 1'b1;
        end
      end
      fdl_pkg::ST_BOOT:
      begin
        d.done = 1'b1;
        d.boot = !(sig_ok && q.flags[fdl_pkg::FLAG_NO_BOOT_ERR] && FATAL_ERROR_IN);
        d.st = fdl_pkg::ST_HOLD;
      end
      fdl_pkg::ST_HOLD:
      begin
        d.boot = q.boot;
        if (START_IN) d.st = fdl_pkg::ST_IDLE;
      end
      default:
      begin
        d.st = fdl_pkg::ST_IDLE;
      end
    endcase
    // cap write transactions at the write size when the signature holds and the write size is nonzero
    d.wr_len = (sig_ok && q.write_size != 16'h0000 && WRITE_REQ_LEN_IN > q.write_size)
      ? q.write_size : WRITE_REQ_LEN_IN;
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      DONE_OUT <= 1'b0;
      DESC_VALID_OUT <= 1'b0;
      QUAD_MODE_OUT <= 1'b0;
      FULL_SPEED_OUT <= 1'b0;
      TURBO_INIT_OUT <= 1'b0;
      BOOT_OUT <= 1'b0;
      IMAGE_ADDR_OUT <= fdl_pkg::IMAGE_START;
      ERASE_SIZE_OUT <= '0;
      WRITE_LEN_OUT <= '0;
      CMDS_OUT <= '0;
      INIT_REQ_OUT <= 1'b0;
      INIT_ENTRY_OUT <= '0;
    end
    else
    begin
      DONE_OUT <= q.done;
      // valid once the load has ended with a good signature, so it always covers enhanced access
      DESC_VALID_OUT <= sig_ok && q.st != fdl_pkg::ST_LOAD;
      // enhanced access only once the switchover entry has run
      QUAD_MODE_OUT <= sig_ok && q.switched;
      FULL_SPEED_OUT <= sig_ok && q.done && q.flags[fdl_pkg::FLAG_FULL_SPEED];
      TURBO_INIT_OUT <= sig_ok && q.flags[fdl_pkg::FLAG_TURBO_INIT];
      BOOT_OUT <= q.boot;
      IMAGE_ADDR_OUT <= fdl_pkg::IMAGE_START;
      ERASE_SIZE_OUT <= sig_ok ? q.erase_size : '0;
      WRITE_LEN_OUT <= q.wr_len;
      CMDS_OUT <= sig_ok ? q.set : '0;
      // next-state copy: the request falls at the very edge that takes INIT_DONE_IN
      INIT_REQ_OUT <= d.init_req && d.st == fdl_pkg::ST_INIT;
      INIT_ENTRY_OUT <= {entry_bits[127:0], entry_bits[255:128], d.run_idx[4:0]};
    end
  end
endmodule

//--- shared/fdl_pkg.sv
// Purpose: constants and types for the flash descriptor loader
// Assumes: descriptor bytes arrive in order from flash byte 0
// Notes: command definitions are kept as raw 128-bit words
package fdl_pkg;
  localparam int unsigned DESC_BYTES = 730;
  localparam logic [23:0] IMAGE_START = 24'h001F84;
  localparam logic [23:0] DESC_AREA_END = 24'h000FFF;
  localparam logic [9:0] OFS_SIG3 = 10'h003;
  localparam logic [9:0] OFS_ERASE_LO = 10'h005;
  localparam logic [9:0] OFS_ERASE_HI = 10'h006;
  localparam logic [9:0] OFS_WRITE_LO = 10'h007;
  localparam logic [9:0] OFS_WRITE_HI = 10'h008;
  localparam logic [9:0] OFS_SET_SLOW = 10'h009;
  localparam logic [9:0] OFS_SET_FAST = 10'h051;
  localparam logic [9:0] SET_BYTES = 10'h048;
  localparam logic [9:0] OFS_INIT = 10'h099;
  localparam logic [9:0] OFS_FLAGS = 10'h2D9;
  localparam logic [6:0] SET_CHIP_ERASE = 7'h00;
  localparam logic [6:0] SET_SECT_ERASE = 7'h10;
  localparam logic [6:0] SET_READ = 7'h20;
  localparam logic [6:0] SET_WRITE = 7'h30;
  localparam logic [6:0] SET_INIT_IDX = 7'h40;
  localparam logic [6:0] SET_INIT_LEN = 7'h42;
  localparam logic [6:0] SET_SWITCH = 7'h44;
  localparam logic [5:0] INIT_ENTRY_BYTES = 6'h20;
  localparam logic [4:0] INIT_ENTRIES = 5'h12;
  localparam logic [31:0] SIGNATURE = 32'hF1A5F1A7;
  localparam int unsigned FLAG_FULL_SPEED = 0;
  localparam int unsigned FLAG_TURBO_INIT = 1;
  localparam int unsigned FLAG_NO_BOOT_ERR = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_INIT = 3'b011,
    ST_BOOT = 3'b010,
    ST_HOLD = 3'b110
  } state_t;

  typedef struct packed {
    logic [127:0] chip_erase;
    logic [127:0] sect_erase;
    logic [127:0] read_cmd;
    logic [127:0] write_cmd;
    logic [15:0] init_idx;
    logic [15:0] init_len;
    logic [15:0] switch_idx;
  } cmd_set_t;

  typedef struct packed {
    logic [127:0] cmd;
    logic [127:0] payload;
    logic [4:0] index;
  } init_req_t;
endpackage
